// ### stp_pkg.sv
// constants and carrier types for the stepper phase sequencer
// Operation
// RULE1: control inputs are sampled and the phase pattern advances only on a rising step clock edge.
// RULE2: excitation mode low selects full-step two-phase drive, high selects half-step 1-2 phase.
// RULE3: direction low steps forward (clockwise), high steps reverse (counter-clockwise).
// RULE4: a low sequencer clear input resets the sequencer state.
// RULE5: while the sequencer clear input is low all four phase outputs are off.
// RULE6: the controller holds the clear input low for at least 10 us after logic power-up.
// RULE7: while output enable is low all four phase outputs are off.
// RULE8: with outputs disabled the sequencer keeps following step edges and resumes in position.
// RULE9: on leaving clear the outputs drive phase A and inverted phase B as the first pattern.
// RULE10: the controller keeps direction stable 6.25 us before and after each step clock rise.
// RULE11: the controller keeps excitation mode stable 5 us before and after each step clock rise.
// RULE12: the controller sets output enable high before stepping begins.
// RULE13: a mode change keeps the position and continues from the nearest step of the new mode.
`default_nettype none

package stp_pkg;

	// position along the eight-entry half-step cycle
	localparam int unsigned POS_W = 3;
	localparam logic [2:0] POS_INIT = 3'h0;
	localparam logic [2:0] POS_ONE = 3'h1;
	localparam logic [2:0] POS_TWO = 3'h2;

	// phase drive pattern, bit order {a, a_inv, b, b_inv}, 1 = winding on
	typedef struct packed {
		logic a;
		logic a_inv;
		logic b;
		logic b_inv;
	} stp_phase_type;

	localparam logic [3:0] PAT_OFF = 4'h0;
	localparam logic [3:0] PAT_0 = 4'h9;
	localparam logic [3:0] PAT_1 = 4'h8;
	localparam logic [3:0] PAT_2 = 4'hA;
	localparam logic [3:0] PAT_3 = 4'h2;
	localparam logic [3:0] PAT_4 = 4'h6;
	localparam logic [3:0] PAT_5 = 4'h4;
	localparam logic [3:0] PAT_6 = 4'h5;
	localparam logic [3:0] PAT_7 = 4'h1;

	// control pins as one bundle
	typedef struct packed {
		logic half_step;
		logic reverse;
		logic enable;
		logic clear_n;
	} stp_ctrl_type;

	// register map, byte addresses on the avalon slave
	localparam int unsigned ADDR_W = 4;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_STEPS = 4'h8;

	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] STEPS_RESET = 32'h0000_0000;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;
	localparam int unsigned CTRL_SW_OFF_BIT = 0;

	// status field positions
	localparam int unsigned ST_POS_LSB = 0;
	localparam int unsigned ST_MODE_BIT = 4;
	localparam int unsigned ST_DIR_BIT = 5;
	localparam int unsigned ST_EN_BIT = 6;
	localparam int unsigned ST_CLR_BIT = 7;
	localparam int unsigned ST_PHASE_LSB = 8;
	localparam int unsigned ST_RUN_BIT = 12;

endpackage : stp_pkg

`default_nettype wire

// ### stp_step_edge.sv
// rising edge detector for the step clock input
`default_nettype none

module stp_step_edge
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic level_in,
	input wire logic arm,
	output logic rise
);

	logic prev_q;
	logic prev_d;

	// previous level starts high so a clock already high at release is no step
	always_comb
	begin
		prev_d = level_in;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			prev_q <= 1'b1;
		else
			prev_q <= prev_d;
	end

	// only a low-to-high change counts, and only while armed
	assign rise = arm & level_in & ~prev_q; // RULE1

endmodule : stp_step_edge

`default_nettype wire

// ### stp_phase_decode.sv
// maps a half-step position to the four phase drive levels
`default_nettype none

module stp_phase_decode
(
	input wire logic [stp_pkg::POS_W-1:0] pos,
	input wire logic force_off,
	output stp_pkg::stp_phase_type pattern
);

	logic [3:0] raw;

	// even positions drive two windings, odd positions one
	always_comb
	begin
		case (pos)
			3'h0: raw = stp_pkg::PAT_0; // RULE9
			3'h1: raw = stp_pkg::PAT_1;
			3'h2: raw = stp_pkg::PAT_2;
			3'h3: raw = stp_pkg::PAT_3;
			3'h4: raw = stp_pkg::PAT_4;
			3'h5: raw = stp_pkg::PAT_5;
			3'h6: raw = stp_pkg::PAT_6;
			3'h7: raw = stp_pkg::PAT_7;
			default: raw = stp_pkg::PAT_OFF;
		endcase
	end

	// gating only masks the drive, the position is untouched
	assign pattern = stp_pkg::stp_phase_type'(force_off ? stp_pkg::PAT_OFF : raw);

endmodule : stp_phase_decode

`default_nettype wire

// ### stp_phase_sequencer.sv
// phase sequencer for a unipolar two-phase stepping motor, with avalon register slave
//
// The implementer's own choices: the register addresses and the Avalon-MM slave port.
`default_nettype none

module stp_phase_sequencer
(
	input wire logic clk,
	input wire logic reset_n,
	// motor control pins from the host controller
	input wire logic step_clock_in,
	input wire logic excitation_mode_in,
	input wire logic rotation_direction_in,
	input wire logic sequencer_clear_n,
	input wire logic output_enable_in,
	// phase drive outputs, high = winding on
	output logic phase_a_out,
	output logic phase_a_inverse_out,
	output logic phase_b_out,
	output logic phase_b_inverse_out,
	// avalon-mm slave
	input wire logic [stp_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);

	// sequencer is either held clear or running
	typedef enum logic [0:0] {
		SEQ_CLEAR,
		SEQ_RUN
	} stp_seq_state_type;

	// slave inserts exactly one wait cycle per access
	typedef enum logic [0:0] {
		BUS_IDLE,
		BUS_ACK
	} stp_bus_state_type;

	// sequencer path
	stp_pkg::stp_ctrl_type ctrl;
	stp_seq_state_type seq_q;
	stp_seq_state_type seq_d;
	logic [stp_pkg::POS_W-1:0] pos_q;
	logic [stp_pkg::POS_W-1:0] pos_d;
	logic [stp_pkg::POS_W-1:0] stride;
	stp_pkg::stp_phase_type phase_q;
	stp_pkg::stp_phase_type phase_d;
	stp_pkg::stp_phase_type pattern;
	logic step_rise;
	logic drive_off;
	logic [stp_pkg::POS_W-1:0] pos_fwd;
	logic [stp_pkg::POS_W-1:0] pos_rev;
	logic step_take;

	// register slave path
	stp_bus_state_type bus_q;
	stp_bus_state_type bus_d;
	logic [31:0] ctrl_reg_q;
	logic [31:0] ctrl_reg_d;
	logic [31:0] steps_q;
	logic [31:0] steps_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [31:0] status_word;
	logic request;
	logic commit_write;
	logic sw_off;
	logic read_take;
	logic hit_ctrl;
	logic hit_status;
	logic hit_steps;

	// bundle the control pins; they are synchronous to clk already
	assign ctrl = '{
		half_step: excitation_mode_in,
		reverse: rotation_direction_in,
		enable: output_enable_in,
		clear_n: sequencer_clear_n
	};

	// step edges are only looked at while the sequencer clear input is high
	stp_step_edge u_step_edge
	(
		.clk(clk),
		.reset_n(reset_n),
		.level_in(step_clock_in),
		.arm(ctrl.clear_n),
		.rise(step_rise)
	);

	// a step counts only once the sequencer runs; the clear state swallows it
	assign step_take = (seq_q == SEQ_RUN) & ctrl.clear_n & step_rise; // RULE1

	// stride per step: half-step moves one position, full-step two;
	// a full-step request from an odd position moves one, landing on
	// the nearest two-phase position in the chosen direction
	always_comb
	begin
		if (ctrl.half_step) // RULE2
			stride = stp_pkg::POS_ONE;
		else if (pos_q[0]) // RULE13
			stride = stp_pkg::POS_ONE;
		else
			stride = stp_pkg::POS_TWO; // RULE2
	end

	// both neighbours are formed every cycle and the direction pin only
	// picks one in the cycle of a step edge; the 3-bit sum wraps the cycle
	always_comb
	begin
		pos_fwd = pos_q + stride;
		pos_rev = pos_q - stride;
	end

	// sequencer state and position; mode and direction are used only
	// in the cycle of a step edge, so their changes elsewhere are harmless
	always_comb
	begin
		seq_d = seq_q;
		pos_d = pos_q;
		case (seq_q)
			SEQ_CLEAR:
			begin
				pos_d = stp_pkg::POS_INIT; // RULE4
				if (ctrl.clear_n)
					seq_d = SEQ_RUN;
			end
			SEQ_RUN:
			begin
				if (!ctrl.clear_n)
				begin
					// clear is a level: position drops back at once
					seq_d = SEQ_CLEAR;
					pos_d = stp_pkg::POS_INIT; // RULE4
				end
				else if (step_rise) // RULE1
				begin
					// position advances whether or not outputs are enabled
					if (ctrl.reverse) // RULE3
						pos_d = pos_rev;
					else
						pos_d = pos_fwd; // RULE8
				end
			end
			default:
			begin
				seq_d = SEQ_CLEAR;
				pos_d = stp_pkg::POS_INIT;
			end
		endcase
	end

	// sequencer registers; the chip reset clears them without a clock
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			seq_q <= SEQ_CLEAR;
			pos_q <= stp_pkg::POS_INIT;
		end
		else
		begin
			seq_q <= seq_d;
			pos_q <= pos_d;
		end
	end

	// the outputs are masked rather than the position, so the timing
	// carries on across a disable window
	assign sw_off = ctrl_reg_q[stp_pkg::CTRL_SW_OFF_BIT];
	assign drive_off = ~ctrl.clear_n | ~ctrl.enable | sw_off; // RULE5 RULE7

	stp_phase_decode u_phase_decode
	(
		.pos(pos_d),
		.force_off(drive_off),
		.pattern(pattern)
	);

	// outputs registered so the drivers never see decode glitches;
	// they follow the new position in the same edge it is taken
	always_comb
	begin
		phase_d = pattern; // RULE9
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			phase_q <= stp_pkg::stp_phase_type'(stp_pkg::PAT_OFF); // RULE5
		else
			phase_q <= phase_d;
	end

	// the four drive pins are the register bits, nothing in between
	assign phase_a_out = phase_q.a;
	assign phase_a_inverse_out = phase_q.a_inv;
	assign phase_b_out = phase_q.b;
	assign phase_b_inverse_out = phase_q.b_inv;

	// status word shows pins as seen, position and live drive pattern
	always_comb
	begin
		status_word = stp_pkg::READ_ZERO;
		status_word[stp_pkg::ST_POS_LSB +: stp_pkg::POS_W] = pos_q;
		status_word[stp_pkg::ST_MODE_BIT] = ctrl.half_step;
		status_word[stp_pkg::ST_DIR_BIT] = ctrl.reverse;
		status_word[stp_pkg::ST_EN_BIT] = ctrl.enable;
		status_word[stp_pkg::ST_CLR_BIT] = ctrl.clear_n;
		status_word[stp_pkg::ST_PHASE_LSB +: 4] = phase_q;
		status_word[stp_pkg::ST_RUN_BIT] = (seq_q == SEQ_RUN);
	end

	// one wait cycle on every access keeps read data registered;
	// the cost is a fixed two-cycle access
	assign request = avs_read | avs_write;
	assign avs_waitrequest = request & (bus_q == BUS_IDLE);
	assign commit_write = avs_write & (bus_q == BUS_ACK);
	assign read_take = avs_read & (bus_q == BUS_IDLE);

	// address decode shared by the read mux and both write paths
	always_comb
	begin
		hit_ctrl = (avs_address == stp_pkg::REG_CTRL);
		hit_status = (avs_address == stp_pkg::REG_STATUS);
		hit_steps = (avs_address == stp_pkg::REG_STEPS);
	end

	always_comb
	begin
		bus_d = bus_q;
		case (bus_q)
			BUS_IDLE:
			begin
				if (request)
					bus_d = BUS_ACK;
			end
			BUS_ACK:
				bus_d = BUS_IDLE;
			default:
				bus_d = BUS_IDLE;
		endcase
	end

	// read data is captured in the wait cycle; unmapped reads give zero
	always_comb
	begin
		rdata_d = rdata_q;
		if (read_take)
		begin
			if (hit_ctrl)
				rdata_d = ctrl_reg_q;
			else if (hit_status)
				rdata_d = status_word;
			else if (hit_steps)
				rdata_d = steps_q;
			else
				rdata_d = stp_pkg::READ_ZERO;
		end
	end

	// control register: only the low lane holds a bit, the rest read zero
	always_comb
	begin
		ctrl_reg_d = ctrl_reg_q;
		if (commit_write && hit_ctrl && avs_byteenable[0])
			ctrl_reg_d[stp_pkg::CTRL_SW_OFF_BIT] = avs_writedata[stp_pkg::CTRL_SW_OFF_BIT];
	end

	// step counter: a write to the steps register clears it, but a step in the same cycle
	// still counts so no edge is lost to the clear
	always_comb
	begin
		steps_d = steps_q;
		if (commit_write && hit_steps)
			steps_d = stp_pkg::STEPS_RESET;
		if (step_take)
			steps_d = steps_d + 32'h0000_0001;
	end

	// slave registers
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			bus_q <= BUS_IDLE;
			ctrl_reg_q <= stp_pkg::CTRL_RESET;
			steps_q <= stp_pkg::STEPS_RESET;
			rdata_q <= stp_pkg::READ_ZERO;
		end
		else
		begin
			bus_q <= bus_d;
			ctrl_reg_q <= ctrl_reg_d;
			steps_q <= steps_d;
			rdata_q <= rdata_d;
		end
	end

	// read data stands from the wait cycle until the next read is taken
	assign avs_readdata = rdata_q;

endmodule : stp_phase_sequencer

`default_nettype wire

// ### stp_seq_chk.sv
// port checker for the stepper phase sequencer
`default_nettype none

module stp_seq_chk
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic step_clock_in,
	input wire logic excitation_mode_in,
	input wire logic rotation_direction_in,
	input wire logic sequencer_clear_n,
	input wire logic output_enable_in,
	input wire logic phase_a_out,
	input wire logic phase_a_inverse_out,
	input wire logic phase_b_out,
	input wire logic phase_b_inverse_out,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest
);
	logic [3:0] ph;
	logic live;
	// pattern in package bit order, and the clear and enable pins both high
	assign ph = {phase_a_out, phase_a_inverse_out, phase_b_out, phase_b_inverse_out};
	assign live = sequencer_clear_n && output_enable_in;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// ph nonzero keeps the software off bit out of the step checks
	sequence s_step;
		$rose(step_clock_in) && live && $past(output_enable_in) && ph != 4'h0;
	endsequence
	sequence s_one_wait;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence
	a_clear_off: assert property (!sequencer_clear_n |=> ph == 4'h0)
		else $error("phase on in clear");
	a_clear_home: assert property ($rose(sequencer_clear_n) && output_enable_in
		&& $past(output_enable_in) && !$rose(step_clock_in) |=> ph == stp_pkg::PAT_0)
		else $error("bad first pattern");
	a_enable_off: assert property (!output_enable_in |=> ph == 4'h0)
		else $error("phase on while disabled");
	a_hold_still: assert property ($past(reset_n) && !$rose(step_clock_in) && !$changed(live)
		&& !avs_write && !$past(avs_write) |=> $stable(ph))
		else $error("pattern moved without step");
	a_half_one: assert property (s_step ##0 excitation_mode_in
		|=> $countones(ph ^ $past(ph)) == 1)
		else $error("half step not one winding");
	a_full_two: assert property (s_step ##0 !excitation_mode_in |=> $countones(ph) == 2)
		else $error("full step not two windings");
	a_dir_sense: assert property (s_step ##0 excitation_mode_in && ph == stp_pkg::PAT_0
		|=> ph == ($past(rotation_direction_in) ? stp_pkg::PAT_7 : stp_pkg::PAT_1))
		else $error("wrong direction");
	a_resume_on: assert property ($rose(output_enable_in) && sequencer_clear_n |=> ph != 4'h0)
		else $error("no resume");
	a_one_wait: assert property ($rose(avs_read || avs_write) |-> s_one_wait)
		else $error("wait cycle count");
endmodule : stp_seq_chk

bind stp_phase_sequencer stp_seq_chk chk_u (.clk, .reset_n, .step_clock_in, .excitation_mode_in,
	.rotation_direction_in, .sequencer_clear_n, .output_enable_in, .phase_a_out,
	.phase_a_inverse_out, .phase_b_out, .phase_b_inverse_out, .avs_read, .avs_write,
	.avs_waitrequest);

`default_nettype wire

// ### stp_host_model.sv
// host controller model driving step clock, mode and direction
`default_nettype none

module stp_host_model
#(
	parameter int HOLD = 1250
)
(
	input wire logic clk,
	output logic step_clock_in,
	output logic excitation_mode_in,
	output logic rotation_direction_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// step clock idles low between frames
	initial
	begin
		step_clock_in = 1'b0;
		excitation_mode_in = 1'b0;
		rotation_direction_in = 1'b0;
	end
	// one frame; mode and direction held a full hold span before and after
	// the rise, the longer of the two spans covering both pins
	task automatic step(input logic half, input logic rev);
		@(posedge clk);
		excitation_mode_in <= half;
		rotation_direction_in <= rev;
		repeat (HOLD) @(posedge clk);
		step_clock_in <= 1'b1;
		repeat (HOLD) @(posedge clk);
		step_clock_in <= 1'b0;
		@(posedge clk);
	endtask : step
endmodule : stp_host_model

`default_nettype wire

// ### stp_phase_sequencer_bench.sv
// self-checking bench for the stepper phase sequencer
`default_nettype none

module stp_phase_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] PAT [8] = '{stp_pkg::PAT_0, stp_pkg::PAT_1, stp_pkg::PAT_2,
		stp_pkg::PAT_3, stp_pkg::PAT_4, stp_pkg::PAT_5, stp_pkg::PAT_6, stp_pkg::PAT_7};
	logic clk, reset_n, clear_n, en, sw, step, mode, dir, avs_read, avs_write, avs_waitrequest;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic [31:0] rd;
	stp_pkg::stp_phase_type ph;
	int n_mismatch = 0;
	int checks = 0;
	int pos = 0;
	int steps = 0;

	// partner keeps the full setup and hold spans around each rise
	stp_host_model host_u (.clk(clk), .step_clock_in(step),
		.excitation_mode_in(mode), .rotation_direction_in(dir));
	stp_phase_sequencer dut_u (.clk(clk), .reset_n(reset_n), .step_clock_in(step),
		.excitation_mode_in(mode), .rotation_direction_in(dir), .sequencer_clear_n(clear_n),
		.output_enable_in(en), .phase_a_out(ph.a), .phase_a_inverse_out(ph.a_inv),
		.phase_b_out(ph.b), .phase_b_inverse_out(ph.b_inv), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize

	task automatic cmp_ph(input logic [3:0] exp);
		checks++;
		if (ph !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t phase got %h exp %h", $time, ph, exp);
		end
	endtask : cmp_ph

	task automatic cmp_rd(input logic [31:0] exp);
		checks++;
		if (rd !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t read got %h exp %h", $time, rd, exp);
		end
	endtask : cmp_rd

	// model of the drive pattern from position and the off conditions
	function automatic logic [3:0] exp_ph();
		return (en && clear_n && !sw) ? PAT[pos] : 4'h0;
	endfunction : exp_ph

	// request stands until waitrequest is sampled low at a rising edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
		@(posedge clk);
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= wd;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus

	// full step from an odd position lands on the nearest even one
	task automatic do_step(input logic m, input logic d);
		host_u.step(m, d);
		if (clear_n)
		begin
			pos = (pos + (d ? -1 : 1) * ((m || pos[0]) ? 1 : 2)) & 7;
			steps++;
		end
		cmp_ph(exp_ph());
	endtask : do_step

	initial
	begin
		repeat (90000) @(posedge clk);
		n_mismatch++;
		summarize();
	end

	initial
	begin
		{reset_n, clear_n, sw, avs_read, avs_write, avs_address, avs_writedata} = '0;
		en = 1'b1;
		void'($urandom(65));
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		repeat (2000) @(posedge clk);
		cmp_ph(4'h0);
		clear_n <= 1'b1;
		repeat (3) @(posedge clk);
		cmp_ph(exp_ph());
		repeat (24)
		begin
			@(posedge clk);
			en <= ($urandom % 4) != 0;
			do_step(1'($urandom), 1'($urandom));
		end
		en <= 1'b1;
		clear_n <= 1'b0;
		pos = 0;
		do_step(1'b1, 1'b0);
		clear_n <= 1'b1;
		repeat (3) @(posedge clk);
		cmp_ph(exp_ph());
		bus(1'b0, stp_pkg::REG_STEPS, 32'h0);
		cmp_rd(32'(steps));
		bus(1'b1, stp_pkg::REG_STEPS, 32'h5);
		bus(1'b0, stp_pkg::REG_STEPS, 32'h0);
		cmp_rd(32'h0);
		bus(1'b0, 4'hC, 32'h0);
		cmp_rd(32'h0);
		bus(1'b0, stp_pkg::REG_STATUS, 32'h0);
		cmp_rd({19'h0, 1'b1, PAT[pos], clear_n, en, dir, mode, 1'b0, 3'(pos)});
		bus(1'b1, stp_pkg::REG_CTRL, 32'h1);
		sw = 1'b1;
		repeat (3) @(posedge clk);
		cmp_ph(exp_ph());
		bus(1'b0, stp_pkg::REG_CTRL, 32'h0);
		cmp_rd(32'h1);
		bus(1'b1, stp_pkg::REG_CTRL, 32'h0);
		sw = 1'b0;
		repeat (3) @(posedge clk);
		cmp_ph(exp_ph());
		do_step(1'b1, 1'b1);
		do_step(1'b1, 1'b0);
		do_step(1'b1, 1'b0);
		do_step(1'b0, 1'b0);
		summarize();
	end
endmodule : stp_phase_sequencer_bench

`default_nettype wire
